// >>> rtl/vpa_map.svh
// register offsets, field positions and reset values of the vc0 port arbitration table block
//
// Contract
// - any software write to the slot table sets the table-dirty flag at bit 16
// - dirty flag stays set until a requested load fully latches, then clears
// - dirty flag only meaningful while a table-driven scheme is selected
// - negotiation-pending flag at bit 17 always reads zero for channel 0
// - eight 4-bit read-write slots, slot 0 at bits 3:0, slot 7 at 31:28
// - a slot naming an invalid port is skipped at once, costing no period
// - codes 0x0 to 0xD select ports 0 to 13, code 0xE selects port 15
// - writing one to load strobe loads the table; zero ignored; reads zero
// - table used only under table-driven schemes; unsupported schemes are undefined
`ifndef VPA_MAP_SVH
`define VPA_MAP_SVH

// ====================================================================
// register offsets
`define VPA_OFS_CTRL        12'h214
`define VPA_OFS_STATUS      12'h218
`define VPA_OFS_TABLE0      12'h240
`define VPA_OFS_INT_STAT    12'h2F0
`define VPA_OFS_INT_MASK    12'h2F4

// ====================================================================
// control register fields
`define VPA_CTRL_TC_MAP_LSB 1
`define VPA_CTRL_TC_MAP_RST 7'h7F
`define VPA_CTRL_LOAD_BIT   16
`define VPA_CTRL_SCHEME_LSB 17
`define VPA_CTRL_VC_EN_BIT  31

// ====================================================================
// status register fields
`define VPA_STS_DIRTY_BIT   16
`define VPA_STS_NEG_BIT     17

// ====================================================================
// slot codes and scheme codes
`define VPA_SLOT_W          4
`define VPA_SLOT_CNT        8
`define VPA_CODE_LAST_DIR   4'hD
`define VPA_CODE_PORT15     4'hE
`define VPA_PORT15          4'hF
`define VPA_SCHEME_TBL_MIN  3'h1
`define VPA_SCHEME_TBL_MAX  3'h5

// ====================================================================
// interrupt status bits
`define VPA_INT_TBL_WR      0
`define VPA_INT_LOAD_DONE   1

`endif

// >>> rtl/vpa_pkg.sv
// types shared by the vc0 port arbitration table block
package vpa_pkg;

  // loader sequencer states
  typedef enum logic [1:0]
  {
    VPA_LD_IDLE = 2'b00,
    VPA_LD_COPY = 2'b01
  } vpa_load_state_type;

  // selected arbitration scheme, as written by software
  typedef enum logic [2:0]
  {
    VPA_SCH_HW_RR   = 3'b000,
    VPA_SCH_WRR32   = 3'b001,
    VPA_SCH_WRR64   = 3'b010,
    VPA_SCH_WRR128  = 3'b011,
    VPA_SCH_TWRR128 = 3'b100,
    VPA_SCH_WRR256  = 3'b101
  } vpa_scheme_type;

endpackage

// >>> rtl/vpa_rr_pick.sv
// rotating first-set finder: first request at or after a start index
`timescale 1ns/100ps
`default_nettype none

module vpa_rr_pick
#(
  parameter int N  = 8,
  parameter int IW = 3
)
(
  input  wire logic [N-1:0]  req_in,
  input  wire logic [IW-1:0] start_in,
  output logic               found_out,
  output logic [IW-1:0]      idx_out
);

  // ==================================================================
  // search
  // one combinational pass, so a skipped entry costs no extra cycle
  always_comb
  begin
    logic [IW-1:0] pos;
    pos       = '0;
    found_out = 1'b0;
    idx_out   = start_in;
    for (int k = 0; k < N; k++)
    begin
      pos = start_in + IW'(k); // wraps because N is a power of two
      if (!found_out && req_in[pos])
      begin
        found_out = 1'b1;
        idx_out   = pos;
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/vpa_table_loader.sv
// copies the software slot table into the arbiter's shadow copy, one slot per cycle
`timescale 1ns/100ps
`default_nettype none
`include "vpa_map.svh"

module vpa_table_loader
#(
  parameter int SLOTS = `VPA_SLOT_CNT,
  parameter int SW    = `VPA_SLOT_W
)
(
  input  wire logic                clk_in,
  input  wire logic                reset_n_in,
  input  wire logic                load_in,
  input  wire logic [SLOTS*SW-1:0] table_in,
  output logic                     busy_out,
  output logic                     done_out,
  output logic [SLOTS*SW-1:0]      shadow_out
);

  vpa_pkg::vpa_load_state_type state_reg;
  logic [$clog2(SLOTS)-1:0]    cnt_reg;

  // ==================================================================
  // sequencer: a load asked for while busy is dropped, the flag stays set
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= vpa_pkg::VPA_LD_IDLE;
      cnt_reg   <= '0;
      done_out  <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      case (state_reg)
        vpa_pkg::VPA_LD_IDLE:
        begin
          cnt_reg <= '0;
          if (load_in)
            state_reg <= vpa_pkg::VPA_LD_COPY;
        end
        vpa_pkg::VPA_LD_COPY:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == ($clog2(SLOTS))'(SLOTS - 1))
          begin
            state_reg <= vpa_pkg::VPA_LD_IDLE;
            done_out  <= 1'b1;
          end
        end
        default:
          state_reg <= vpa_pkg::VPA_LD_IDLE;
      endcase
    end
  end

  // ==================================================================
  // shadow copy, one nibble per cycle
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      shadow_out <= '0;
    else if (state_reg == vpa_pkg::VPA_LD_COPY)
      shadow_out[cnt_reg*SW +: SW] <= table_in[cnt_reg*SW +: SW];
  end

  assign busy_out = (state_reg == vpa_pkg::VPA_LD_COPY);

endmodule

`default_nettype wire

// >>> rtl/vpa_vc0_arb_table.sv
// vc0 port arbitration table, its coherency status and the slot-walking arbiter
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "vpa_map.svh"

module vpa_vc0_arb_table
#(
  parameter int         ADDR_W      = 12,
  parameter int         PORT_CNT    = 16,
  parameter logic [3:0] EGRESS_PORT = 4'hE
)
(
  input  wire logic                clk_in,
  input  wire logic                reset_n_in,
  input  wire logic [ADDR_W-1:0]   reg_addr_in,
  input  wire logic [31:0]         reg_wr_data_in,
  input  wire logic                reg_wr_en_in,
  input  wire logic                reg_rd_en_in,
  output logic      [31:0]         reg_rd_data_out,
  input  wire logic [PORT_CNT-1:0] port_valid_in,
  input  wire logic                period_tick_in,
  output logic                     grant_valid_out,
  output logic      [3:0]          grant_port_out,
  output logic                     table_mode_out,
  output logic                     irq_out
);

  localparam int SLOTS = `VPA_SLOT_CNT;
  localparam int SW    = `VPA_SLOT_W;

  // ==================================================================
  // register state
  logic [SLOTS*SW-1:0]      table_reg;
  logic [6:0]               tc_map_reg;
  vpa_pkg::vpa_scheme_type  scheme_reg;
  logic                     dirty_reg;
  logic                     wr_in_copy_reg;
  logic [1:0]               int_stat_reg;
  logic [1:0]               int_stat_next;
  logic [1:0]               int_mask_reg;
  logic [2:0]               slot_ptr_reg;
  logic [3:0]               port_ptr_reg;

  // ==================================================================
  // write decode
  // addresses are compared in full, so nothing aliases across the map
  logic wr_ctrl;
  logic wr_table;
  logic wr_int_stat;
  logic wr_int_mask;
  logic load_req;

  assign wr_ctrl     = reg_wr_en_in && (reg_addr_in == `VPA_OFS_CTRL);
  assign wr_table    = reg_wr_en_in && (reg_addr_in == `VPA_OFS_TABLE0);
  assign wr_int_stat = reg_wr_en_in && (reg_addr_in == `VPA_OFS_INT_STAT);
  assign wr_int_mask = reg_wr_en_in && (reg_addr_in == `VPA_OFS_INT_MASK);
  // only a one starts a load; the strobe itself is never stored
  assign load_req    = wr_ctrl && reg_wr_data_in[`VPA_CTRL_LOAD_BIT];

  // ==================================================================
  // loader and the shadow table that the arbiter really uses
  // the copy takes one slot per cycle; the arbiter keeps running meanwhile
  // and may grant from a mix of old and new slots until the copy is over,
  // which is why software must wait for the dirty flag before trusting it
  logic                load_busy;
  logic                load_done;
  logic [SLOTS*SW-1:0] shadow_table;

  vpa_table_loader
  #(
    .SLOTS (SLOTS),
    .SW    (SW)
  )
  u_loader
  (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .load_in    (load_req),
    .table_in   (table_reg),
    .busy_out   (load_busy),
    .done_out   (load_done),
    .shadow_out (shadow_table)
  );

  // ==================================================================
  // software table, slot i at bits 4i+3:4i
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      table_reg <= '0;
    else if (wr_table)
      table_reg <= reg_wr_data_in;
  end

  // ==================================================================
  // control fields: traffic class map and scheme select
  // the fixed bits of the control word are not stored; the read mux makes them
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tc_map_reg <= `VPA_CTRL_TC_MAP_RST;
      scheme_reg <= vpa_pkg::VPA_SCH_HW_RR;
    end
    else if (wr_ctrl)
    begin
      tc_map_reg <= reg_wr_data_in[`VPA_CTRL_TC_MAP_LSB +: 7];
      scheme_reg <= vpa_pkg::vpa_scheme_type'(reg_wr_data_in[`VPA_CTRL_SCHEME_LSB +: 3]);
    end
  end

  // ==================================================================
  // table write seen while the copy runs: the shadow then holds part old,
  // part new contents, so the end of that copy must not clear the flag
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      wr_in_copy_reg <= 1'b0;
    else if (wr_table && load_busy)
      wr_in_copy_reg <= 1'b1;
    else if (!load_busy)
      wr_in_copy_reg <= 1'b0;
  end

  // ==================================================================
  // table-dirty flag: a table write in the done cycle wins over the clear
  // after a copy that raced a table write the flag stays set, telling
  // software that it has to ask for another load
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      dirty_reg <= 1'b0;
    else if (wr_table)
      dirty_reg <= 1'b1;
    else if (load_done && !wr_in_copy_reg)
      dirty_reg <= 1'b0;
  end

  // ==================================================================
  // scheme classification
  // unsupported codes fall back to the hardware round robin; the
  // behaviour there is undefined anyway, so this just keeps it safe
  logic table_driven;

  assign table_driven = (scheme_reg >= `VPA_SCHEME_TBL_MIN) &&
                        (scheme_reg <= `VPA_SCHEME_TBL_MAX);

  // ==================================================================
  // per-slot port decode and validity
  // decoded straight off the shadow copy, so a change of port validity
  // takes effect in the very next period
  logic [3:0]       slot_port [SLOTS];
  logic [SLOTS-1:0] slot_ok;

  generate
    for (genvar i = 0; i < SLOTS; i++)
    begin : g_slot
      logic [3:0] code;
      logic       mapped;
      assign code   = shadow_table[i*SW +: SW];
      // 0x0..0xD map straight through, 0xE means port 15, 0xF is unused
      assign mapped = (code <= `VPA_CODE_LAST_DIR) || (code == `VPA_CODE_PORT15);
      assign slot_port[i] = (code == `VPA_CODE_PORT15) ? `VPA_PORT15 : code;
      // the egress port itself is treated as invalid rather than granted
      assign slot_ok[i] = mapped && port_valid_in[slot_port[i]] &&
                          (slot_port[i] != EGRESS_PORT);
    end
  endgenerate

  // ==================================================================
  // slot search from the current phase, invalid slots skipped in zero time
  logic       slot_found;
  logic [2:0] slot_idx;

  vpa_rr_pick
  #(
    .N  (SLOTS),
    .IW (3)
  )
  u_slot_pick
  (
    .req_in    (slot_ok),
    .start_in  (slot_ptr_reg),
    .found_out (slot_found),
    .idx_out   (slot_idx)
  );

  // ==================================================================
  // hardware round robin over live ports when no table scheme is selected
  // the egress port never competes, whatever its valid bit says
  logic [PORT_CNT-1:0] port_req;
  logic                port_found;
  logic [3:0]          port_idx;

  always_comb
  begin
    port_req = port_valid_in;
    port_req[EGRESS_PORT] = 1'b0;
  end

  vpa_rr_pick
  #(
    .N  (PORT_CNT),
    .IW (4)
  )
  u_port_pick
  (
    .req_in    (port_req),
    .start_in  (port_ptr_reg),
    .found_out (port_found),
    .idx_out   (port_idx)
  );

  // ==================================================================
  // arbitration period: one grant per tick, pointer moves past the winner
  // a period with nothing to grant leaves both pointers where they were,
  // so the next period starts its search from the same phase
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      slot_ptr_reg    <= 3'h0;
      port_ptr_reg    <= 4'h0;
      grant_valid_out <= 1'b0;
      grant_port_out  <= 4'h0;
    end
    else
    begin
      grant_valid_out <= 1'b0;
      if (period_tick_in && table_driven)
      begin
        if (slot_found)
        begin
          grant_valid_out <= 1'b1;
          grant_port_out  <= slot_port[slot_idx];
          slot_ptr_reg    <= slot_idx + 3'h1;
        end
      end
      else if (period_tick_in && port_found)
      begin
        grant_valid_out <= 1'b1;
        grant_port_out  <= port_idx;
        port_ptr_reg    <= port_idx + 4'h1;
      end
    end
  end

  // ==================================================================
  // scheme indicator; the dirty flag is only meaningful while this is high
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      table_mode_out <= 1'b0;
    else
      table_mode_out <= table_driven;
  end

  // ==================================================================
  // interrupt status: write one to clear, a new event wins over the clear
  // load done comes from the loader's registered pulse, so its bit sets in
  // the same cycle in which a clean load clears the dirty flag
  always_comb
  begin
    int_stat_next = int_stat_reg;
    if (wr_int_stat)
      int_stat_next = int_stat_reg & ~reg_wr_data_in[1:0];
    if (wr_table)
      int_stat_next[`VPA_INT_TBL_WR] = 1'b1;
    if (load_done)
      int_stat_next[`VPA_INT_LOAD_DONE] = 1'b1;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      int_stat_reg <= 2'h0;
    else
      int_stat_reg <= int_stat_next;
  end

  // mask register
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      int_mask_reg <= 2'h0;
    else if (wr_int_mask)
      int_mask_reg <= reg_wr_data_in[1:0];
  end

  // level interrupt, one cycle behind the status it reflects
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(int_stat_reg & int_mask_reg);
  end

  // ==================================================================
  // read mux; unmapped addresses return zero
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (reg_addr_in)
      `VPA_OFS_CTRL:
      begin
        rd_mux[0]                          = 1'b1;
        rd_mux[`VPA_CTRL_TC_MAP_LSB +: 7]  = tc_map_reg;
        rd_mux[`VPA_CTRL_LOAD_BIT]         = 1'b0;
        rd_mux[`VPA_CTRL_SCHEME_LSB +: 3]  = scheme_reg;
        rd_mux[`VPA_CTRL_VC_EN_BIT]        = 1'b1;
      end
      `VPA_OFS_STATUS:
      begin
        rd_mux[`VPA_STS_DIRTY_BIT] = dirty_reg;
        rd_mux[`VPA_STS_NEG_BIT]   = 1'b0;
      end
      `VPA_OFS_TABLE0:
        rd_mux = table_reg;
      `VPA_OFS_INT_STAT:
        rd_mux[1:0] = int_stat_reg;
      `VPA_OFS_INT_MASK:
        rd_mux[1:0] = int_mask_reg;
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  // returning zero between reads means a late sample shows zero rather
  // than an old status word that could be mistaken for a fresh one
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      reg_rd_data_out <= 32'h0000_0000;
    else if (reg_rd_en_in)
      reg_rd_data_out <= rd_mux;
    else
      reg_rd_data_out <= 32'h0000_0000;
  end

endmodule

`default_nettype wire

// >>> verification/vpa_vc0_arb_table_asserts.sv
// concurrent checks on the ports of the vc0 port arbitration table block
`timescale 1ns/100ps
`default_nettype none
`include "vpa_map.svh"

module vpa_vc0_arb_table_asserts
#(
  parameter int         ADDR_W      = 12,
  parameter int         PORT_CNT    = 16,
  parameter logic [3:0] EGRESS_PORT = 4'hE
)
(
  input wire logic                clk_in,
  input wire logic                reset_n_in,
  input wire logic [ADDR_W-1:0]   reg_addr_in,
  input wire logic [31:0]         reg_wr_data_in,
  input wire logic                reg_wr_en_in,
  input wire logic                reg_rd_en_in,
  input wire logic [31:0]         reg_rd_data_out,
  input wire logic [PORT_CNT-1:0] port_valid_in,
  input wire logic                period_tick_in,
  input wire logic                grant_valid_out,
  input wire logic [3:0]          grant_port_out,
  input wire logic                table_mode_out,
  input wire logic                irq_out
);
  logic [PORT_CNT-1:0] pv_reg;
  logic                mode_exp;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // ====================================================================
  // helper logic
  // port validity as the arbiter saw it at the tick edge
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pv_reg <= '0;
    else
      pv_reg <= port_valid_in;
  end

  // scheme codes 1 to 5 are the table-driven ones
  assign mode_exp = (reg_wr_data_in[19:17] >= `VPA_SCHEME_TBL_MIN) &&
                    (reg_wr_data_in[19:17] <= `VPA_SCHEME_TBL_MAX);

  // ====================================================================
  // assertions
  a_grant_after_tick: assert property (grant_valid_out |-> $past(period_tick_in))
    else $error("grant without a period tick");
  a_grant_port_legal: assert property (grant_valid_out |->
    pv_reg[grant_port_out] && grant_port_out != EGRESS_PORT)
    else $error("grant to an invalid port");
  a_grant_port_holds: assert property (!grant_valid_out |-> $stable(grant_port_out))
    else $error("grant port moved without a grant");
  a_rd_data_idle: assert property (!$past(reg_rd_en_in) |-> reg_rd_data_out == 32'h0)
    else $error("read data outside its cycle");
  a_status_fixed_zero: assert property ($past(reg_rd_en_in) &&
    $past(reg_addr_in) == `VPA_OFS_STATUS |->
    reg_rd_data_out[31:17] == 15'h0 && reg_rd_data_out[15:0] == 16'h0)
    else $error("status fixed bits not zero");
  a_ctrl_strobe_zero: assert property ($past(reg_rd_en_in) &&
    $past(reg_addr_in) == `VPA_OFS_CTRL |->
    !reg_rd_data_out[16] && reg_rd_data_out[31] && reg_rd_data_out[0])
    else $error("control load strobe reads one");
  a_dirty_after_write: assert property (reg_wr_en_in && reg_addr_in == `VPA_OFS_TABLE0
    ##1 reg_rd_en_in && reg_addr_in == `VPA_OFS_STATUS |=> reg_rd_data_out[16])
    else $error("dirty flag not set by table write");
  a_table_readback: assert property (reg_wr_en_in && reg_addr_in == `VPA_OFS_TABLE0
    ##1 reg_rd_en_in && reg_addr_in == `VPA_OFS_TABLE0 |=>
    reg_rd_data_out == $past(reg_wr_data_in, 2))
    else $error("slot table readback differs");
  a_scheme_mode: assert property (reg_wr_en_in && reg_addr_in == `VPA_OFS_CTRL |->
    ##2 table_mode_out == $past(mode_exp, 2))
    else $error("table mode does not follow scheme");

  // main scenarios reached
  c_grant: cover property (grant_valid_out);
  c_load: cover property (reg_wr_en_in && reg_addr_in == `VPA_OFS_CTRL && reg_wr_data_in[16]);
  c_irq: cover property ($rose(irq_out));
endmodule

bind vpa_vc0_arb_table vpa_vc0_arb_table_asserts
  #(.ADDR_W(ADDR_W), .PORT_CNT(PORT_CNT), .EGRESS_PORT(EGRESS_PORT)) u_chk
  (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
   .reg_wr_data_in(reg_wr_data_in), .reg_wr_en_in(reg_wr_en_in),
   .reg_rd_en_in(reg_rd_en_in), .reg_rd_data_out(reg_rd_data_out),
   .port_valid_in(port_valid_in), .period_tick_in(period_tick_in),
   .grant_valid_out(grant_valid_out), .grant_port_out(grant_port_out),
   .table_mode_out(table_mode_out), .irq_out(irq_out));
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking testbench of the vc0 port arbitration table block
`timescale 1ns/100ps
`default_nettype none
`include "vpa_map.svh"

module tb_top;
  logic        clk_in;
  logic        reset_n_in;
  logic [11:0] reg_addr_in;
  logic [31:0] reg_wr_data_in;
  logic        reg_wr_en_in;
  logic        reg_rd_en_in;
  logic [31:0] reg_rd_data_out;
  logic [15:0] port_valid_in;
  logic        period_tick_in;
  logic        grant_valid_out;
  logic [3:0]  grant_port_out;
  logic        table_mode_out;
  logic        irq_out;
  int          err_count;
  int          n_tests;
  // slots 7..0: 1, 7, 0, D, 5(invalid), 9, E(port 15), 3; no reserved or egress code
  localparam logic [31:0] TBL = 32'h170D59E3;
  logic [3:0]  exp_ports [8] = '{4'h3, 4'hF, 4'h9, 4'hD, 4'h0, 4'h7, 4'h1, 4'h3};

  vpa_vc0_arb_table u_vpa_vc0_arb_table
  (
    .clk_in          (clk_in),
    .reset_n_in      (reset_n_in),
    .reg_addr_in     (reg_addr_in),
    .reg_wr_data_in  (reg_wr_data_in),
    .reg_wr_en_in    (reg_wr_en_in),
    .reg_rd_en_in    (reg_rd_en_in),
    .reg_rd_data_out (reg_rd_data_out),
    .port_valid_in   (port_valid_in),
    .period_tick_in  (period_tick_in),
    .grant_valid_out (grant_valid_out),
    .grant_port_out  (grant_port_out),
    .table_mode_out  (table_mode_out),
    .irq_out         (irq_out)
  );

  // ====================================================================
  // clock and watchdog
  // 200 MHz core clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge clk_in);
    err_count++;
    tally_and_finish();
  end

  // ====================================================================
  // tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_en_in   <= 1'b1;
    reg_addr_in    <= a;
    reg_wr_data_in <= d;
    @(posedge clk_in);
    reg_wr_en_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so look just after that edge
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
    @(posedge clk_in);
    reg_rd_en_in <= 1'b1;
    reg_addr_in  <= a;
    @(posedge clk_in);
    reg_rd_en_in <= 1'b0;
    #1;
    check(name, exp, reg_rd_data_out);
  endtask

  // write followed by a read with no gap between the strobes
  task automatic wr_rd(input logic [11:0] wa, input logic [31:0] d, input logic [11:0] ra,
                       input logic [31:0] exp, input string name);
    @(posedge clk_in);
    reg_wr_en_in   <= 1'b1;
    reg_addr_in    <= wa;
    reg_wr_data_in <= d;
    @(posedge clk_in);
    reg_wr_en_in <= 1'b0;
    reg_rd_en_in <= 1'b1;
    reg_addr_in  <= ra;
    @(posedge clk_in);
    reg_rd_en_in <= 1'b0;
    #1;
    check(name, exp, reg_rd_data_out);
  endtask

  // irq lags the status by one cycle, two edges leave room for it
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk_in);
    #1;
    check("irq_out", {31'h0, exp}, {31'h0, irq_out});
  endtask

  task automatic tick(input logic exp_v, input logic [3:0] exp_p);
    @(posedge clk_in);
    period_tick_in <= 1'b1;
    @(posedge clk_in);
    period_tick_in <= 1'b0;
    #1;
    check("grant_valid_out", {31'h0, exp_v}, {31'h0, grant_valid_out});
    if (exp_v)
      check("grant_port_out", {28'h0, exp_p}, {28'h0, grant_port_out});
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d of %0d comparisons", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ====================================================================
  // main sequence
  initial
  begin
    err_count      = 0;
    n_tests        = 0;
    reset_n_in     = 1'b0;
    reg_addr_in    = 12'h000;
    reg_wr_data_in = 32'h0;
    reg_wr_en_in   = 1'b0;
    reg_rd_en_in   = 1'b0;
    port_valid_in  = 16'hFFDF;
    period_tick_in = 1'b0;
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(`VPA_OFS_CTRL, 32'h800000FF, "ctrl");
    rd(`VPA_OFS_STATUS, 32'h0, "status");
    rd(`VPA_OFS_TABLE0, 32'h0, "table");
    rd(`VPA_OFS_INT_STAT, 32'h0, "int_stat");
    rd(12'h300, 32'h0, "unmapped");
    irq_is(1'b0);
    wr(`VPA_OFS_INT_MASK, 32'h1);
    wr_rd(`VPA_OFS_TABLE0, TBL, `VPA_OFS_STATUS, 32'h00010000, "status");
    rd(`VPA_OFS_TABLE0, TBL, "table");
    irq_is(1'b1);
    wr(`VPA_OFS_STATUS, 32'hFFFFFFFF);
    rd(`VPA_OFS_STATUS, 32'h00010000, "status");
    // scheme 1 with the load bit clear must leave the dirty flag alone
    wr(`VPA_OFS_CTRL, 32'h000200FE);
    repeat (12) @(posedge clk_in);
    rd(`VPA_OFS_STATUS, 32'h00010000, "status");
    rd(`VPA_OFS_CTRL, 32'h800200FF, "ctrl");
    check("table_mode_out", 32'h1, {31'h0, table_mode_out});
    // load request: dirty holds while the copy runs, then clears
    wr(`VPA_OFS_CTRL, 32'h000300FE);
    rd(`VPA_OFS_STATUS, 32'h00010000, "status");
    repeat (10) @(posedge clk_in);
    rd(`VPA_OFS_STATUS, 32'h0, "status");
    rd(`VPA_OFS_CTRL, 32'h800200FF, "ctrl");
    rd(`VPA_OFS_INT_STAT, 32'h3, "int_stat");
    wr(`VPA_OFS_INT_STAT, 32'h1);
    rd(`VPA_OFS_INT_STAT, 32'h2, "int_stat");
    irq_is(1'b0);
    wr(`VPA_OFS_INT_MASK, 32'h3);
    irq_is(1'b1);
    wr(`VPA_OFS_INT_STAT, 32'h2);
    irq_is(1'b0);
    // slot walk, port 5 invalid, wraps after slot 7
    for (int i = 0; i < 8; i++)
      tick(1'b1, exp_ports[i]);
    // a new table is not used until loaded
    wr_rd(`VPA_OFS_TABLE0, 32'h22222222, `VPA_OFS_TABLE0, 32'h22222222, "table");
    tick(1'b1, 4'hF);
    @(posedge clk_in);
    port_valid_in <= 16'h0000;
    tick(1'b0, 4'h0);
    wr(`VPA_OFS_CTRL, 32'h000000FE);
    repeat (3) @(posedge clk_in);
    #1;
    check("table_mode_out", 32'h0, {31'h0, table_mode_out});
    // scheme 5 is the last table-driven code, 6 is unsupported and runs round robin
    wr(`VPA_OFS_CTRL, 32'h000A00FE);
    repeat (3) @(posedge clk_in);
    #1;
    check("table_mode_out", 32'h1, {31'h0, table_mode_out});
    wr(`VPA_OFS_CTRL, 32'h000C00FE);
    port_valid_in <= 16'h4022;
    tick(1'b1, 4'h1);
    tick(1'b1, 4'h5);
    tick(1'b1, 4'h1);
    check("table_mode_out", 32'h0, {31'h0, table_mode_out});
    rd(`VPA_OFS_CTRL, 32'h800C00FF, "ctrl");
    tally_and_finish();
  end
endmodule
`default_nettype wire
